// file: hw/mhu_defines.svh
// Constants for the module host serial port
`ifndef MHU_DEFINES_SVH
`define MHU_DEFINES_SVH
// Overview of operation
// - One serial channel; receiver and transmitter run at the same time.
// - Each received character becomes a parallel word for the processor.
// - Each word from the processor is shifted out on the transmit line.
// - Data moves only on receive line in and transmit line out.
// - Request-to-send and clear-to-send are active low.
// - Flow control selects RTS/CTS handshaking or none.
// - Bit rate set from 1200 to 625000 baud, default 115200.
// - Parity none, odd or even, sent after the data bits.
// - Stop bits one, one and a half or two bit periods.
// - Character width five, six, seven or eight data bits.
`define MHU_CLK_HZ       10000000
`define MHU_BAUD_DEF     115200
`define MHU_OVS          16
// Divider for 16x tick, rounded to nearest
`define MHU_DIV_DEF      ((`MHU_CLK_HZ + (`MHU_BAUD_DEF * `MHU_OVS) / 2) / (`MHU_BAUD_DEF * `MHU_OVS))
`define MHU_PAR_NONE     2'h0
`define MHU_PAR_ODD      2'h1
`define MHU_PAR_EVEN     2'h2
`define MHU_STOP_1       2'h0
`define MHU_STOP_1P5     2'h1
`define MHU_STOP_2       2'h2
`endif

// file: hw/mhu_pkg.sv
// Types for the module host serial port
package mhu_pkg;
	typedef struct packed {
		logic [1:0] parity;
		logic [1:0] stops;
		logic [1:0] width;
		logic       flow_en;
	} mhu_cfg_t;
	typedef enum logic [2:0] {
		MHU_IDLE  = 3'h0,
		MHU_START = 3'h1,
		MHU_DATA  = 3'h3,
		MHU_PAR   = 3'h2,
		MHU_STOP  = 3'h6
	} mhu_state_t;
endpackage

// file: hw/mhu_uart.sv
// Full-duplex serial port with optional RTS/CTS flow control
`timescale 1ns/1ps
`default_nettype none
`include "mhu_defines.svh"
module mhu_uart #(
	parameter int DIV_W = 16
) (
	// Clock and reset
	input  wire logic            clk,
	input  wire logic            rstn,
	// Configuration
	input  wire logic [DIV_W-1:0] baud_div,
	input  wire mhu_pkg::mhu_cfg_t cfg,
	// Transmit word from processor
	input  wire logic            tx_valid,
	input  wire logic [7:0]      tx_data,
	output logic                 tx_ready,
	// Received word to processor
	output logic                 rx_valid,
	output logic [7:0]           rx_data,
	output logic                 rx_par_err,
	output logic                 rx_frm_err,
	input  wire logic            rx_room,
	// Serial pins
	input  wire logic            rxd,
	output logic                 txd,
	input  wire logic            cts_n,
	output logic                 rts_n
);
	// Divider must reach slow rates yet stay a small counter
	if (DIV_W < 4 || DIV_W > 24) begin : g_div_w_check
		$error("DIV_W out of range");
	end
	//////////////////////////////////////////////////////////////////////////
	// Oversample tick, shared by both directions
	logic [DIV_W-1:0] div_cnt, next_div_cnt;
	logic             tick;
	always_comb begin
		tick = (div_cnt == '0);
		next_div_cnt = tick ? ((baud_div == '0) ? DIV_W'(1) : baud_div) - DIV_W'(1)
		                    : div_cnt - DIV_W'(1);
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			div_cnt <= '0;
		else
			div_cnt <= next_div_cnt;
	end
	//////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [1:0] rx_sync, cts_sync;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_sync  <= 2'h3;
			cts_sync <= 2'h3;
		end else begin
			rx_sync  <= {rx_sync[0], rxd};
			cts_sync <= {cts_sync[0], cts_n};
		end
	end
	logic rx_in, cts_ok;
	assign rx_in  = rx_sync[1];
	assign cts_ok = !cfg.flow_en || !cts_sync[1];
	// Stop length in ticks: 16, 24 or 32
	function automatic logic [5:0] stop_ticks(input logic [1:0] s);
		unique case (s)
			`MHU_STOP_1P5: stop_ticks = 6'h18;
			`MHU_STOP_2:   stop_ticks = 6'h20;
			default:       stop_ticks = 6'h10;
		endcase
	endfunction
	//////////////////////////////////////////////////////////////////////////
	// Transmitter
	mhu_pkg::mhu_state_t tx_st, next_tx_st;
	logic [5:0] tx_tk, next_tx_tk;
	logic [2:0] tx_bit, next_tx_bit;
	logic [7:0] tx_sh, next_tx_sh;
	logic       tx_par, next_tx_par;
	logic       next_txd;
	assign tx_ready = (tx_st == mhu_pkg::MHU_IDLE) && cts_ok;
	always_comb begin
		next_tx_st  = tx_st;
		next_tx_tk  = tx_tk;
		next_tx_bit = tx_bit;
		next_tx_sh  = tx_sh;
		next_tx_par = tx_par;
		next_txd    = txd;
		unique case (tx_st)
			mhu_pkg::MHU_IDLE: begin
				next_txd = 1'b1;
				if (tx_valid && tx_ready) begin
					next_tx_st  = mhu_pkg::MHU_START;
					next_tx_sh  = tx_data;
					next_tx_par = (cfg.parity == `MHU_PAR_ODD);
					next_tx_tk  = 6'h0F;
					next_tx_bit = 3'h0;
					next_txd    = 1'b0;
				end
			end
			default: begin
				if (tick) begin
					next_tx_tk = tx_tk - 6'h01;
					if (tx_tk == 6'h00) begin
						next_tx_tk = 6'h0F;
						if (tx_st == mhu_pkg::MHU_START ||
						    (tx_st == mhu_pkg::MHU_DATA && tx_bit != {1'b1, cfg.width})) begin
							if (tx_st == mhu_pkg::MHU_DATA)
								next_tx_bit = tx_bit + 3'h1;
							next_tx_st  = mhu_pkg::MHU_DATA;
							next_txd    = tx_sh[0];
							next_tx_par = tx_par ^ tx_sh[0];
							next_tx_sh  = {1'b0, tx_sh[7:1]};
						end else if (tx_st == mhu_pkg::MHU_DATA &&
						             cfg.parity != `MHU_PAR_NONE) begin
							next_tx_st = mhu_pkg::MHU_PAR;
							next_txd   = tx_par;
						end else if (tx_st != mhu_pkg::MHU_STOP) begin
							next_tx_st = mhu_pkg::MHU_STOP;
							next_txd   = 1'b1;
							next_tx_tk = stop_ticks(cfg.stops) - 6'h01;
						end else begin
							next_tx_st = mhu_pkg::MHU_IDLE;
						end
					end
				end
			end
		endcase
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_st  <= mhu_pkg::MHU_IDLE;
			tx_tk  <= 6'h00;
			tx_bit <= 3'h0;
			tx_sh  <= 8'h00;
			tx_par <= 1'b0;
			txd    <= 1'b1;
		end else begin
			tx_st  <= next_tx_st;
			tx_tk  <= next_tx_tk;
			tx_bit <= next_tx_bit;
			tx_sh  <= next_tx_sh;
			tx_par <= next_tx_par;
			txd    <= next_txd;
		end
	end
	//////////////////////////////////////////////////////////////////////////
	// Receiver
	mhu_pkg::mhu_state_t rx_st, next_rx_st;
	logic [3:0] rx_tk, next_rx_tk;
	logic [2:0] rx_bit, next_rx_bit;
	logic [7:0] rx_sh, next_rx_sh;
	logic       rx_par, next_rx_par;
	logic       rx_perr, next_rx_perr;
	logic       next_rx_valid, next_rx_par_err, next_rx_frm_err;
	logic [7:0] next_rx_data;
	logic       next_rts_n;
	always_comb begin
		next_rx_st      = rx_st;
		next_rx_tk      = rx_tk;
		next_rx_bit     = rx_bit;
		next_rx_sh      = rx_sh;
		next_rx_par     = rx_par;
		next_rx_perr    = rx_perr;
		next_rx_valid   = 1'b0;
		next_rx_data    = rx_data;
		next_rx_par_err = rx_par_err;
		next_rx_frm_err = rx_frm_err;
		// Low asks the host to send; without flow control always low
		next_rts_n      = cfg.flow_en ? !rx_room : 1'b0;
		unique case (rx_st)
			mhu_pkg::MHU_IDLE: begin
				// A low input level while idle starts bit timing
				if (!rx_in) begin
					next_rx_st = mhu_pkg::MHU_START;
					next_rx_tk = 4'h7;
				end
			end
			default: begin
				if (tick) begin
					next_rx_tk = rx_tk - 4'h1;
					if (rx_tk == 4'h0) begin
						next_rx_tk = 4'hF;
						unique case (rx_st)
							mhu_pkg::MHU_START: begin
								// Glitch shorter than half a bit is dropped
								next_rx_st   = rx_in ? mhu_pkg::MHU_IDLE : mhu_pkg::MHU_DATA;
								next_rx_bit  = 3'h0;
								next_rx_sh   = 8'h00;
								next_rx_par  = (cfg.parity == `MHU_PAR_ODD);
								next_rx_perr = 1'b0;
							end
							mhu_pkg::MHU_DATA: begin
								next_rx_sh  = {rx_in, rx_sh[7:1]};
								next_rx_par = rx_par ^ rx_in;
								next_rx_bit = rx_bit + 3'h1;
								if (rx_bit == {1'b1, cfg.width})
									next_rx_st = (cfg.parity != `MHU_PAR_NONE) ?
									             mhu_pkg::MHU_PAR : mhu_pkg::MHU_STOP;
							end
							mhu_pkg::MHU_PAR: begin
								next_rx_perr = rx_par ^ rx_in;
								next_rx_st   = mhu_pkg::MHU_STOP;
							end
							default: begin
								// Only first stop bit checked, so 1.5 and 2 receive alike
								next_rx_st      = mhu_pkg::MHU_IDLE;
								next_rx_valid   = 1'b1;
								next_rx_data    = rx_sh >> (3'h3 - {1'b0, cfg.width});
								next_rx_par_err = rx_perr;
								next_rx_frm_err = !rx_in;
							end
						endcase
					end
				end
			end
		endcase
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_st      <= mhu_pkg::MHU_IDLE;
			rx_tk      <= 4'h0;
			rx_bit     <= 3'h0;
			rx_sh      <= 8'h00;
			rx_par     <= 1'b0;
			rx_perr    <= 1'b0;
			rx_valid   <= 1'b0;
			rx_data    <= 8'h00;
			rx_par_err <= 1'b0;
			rx_frm_err <= 1'b0;
			rts_n      <= 1'b1;
		end else begin
			rx_st      <= next_rx_st;
			rx_tk      <= next_rx_tk;
			rx_bit     <= next_rx_bit;
			rx_sh      <= next_rx_sh;
			rx_par     <= next_rx_par;
			rx_perr    <= next_rx_perr;
			rx_valid   <= next_rx_valid;
			rx_data    <= next_rx_data;
			rx_par_err <= next_rx_par_err;
			rx_frm_err <= next_rx_frm_err;
			rts_n      <= next_rts_n;
		end
	end
endmodule
`default_nettype wire

// file: sim/mhu_uart_properties.sv
// Assertion checker for the module host serial port
`timescale 1ns/1ps
`default_nettype none
module mhu_uart_chk (
	// Clock, reset, configuration
	input wire logic              clk,
	input wire logic              rstn,
	input wire mhu_pkg::mhu_cfg_t cfg,
	// Words and pins
	input wire logic              tx_valid,
	input wire logic              tx_ready,
	input wire logic              rx_valid,
	input wire logic [7:0]        rx_data,
	input wire logic              rx_par_err,
	input wire logic              rx_room,
	input wire logic              txd,
	input wire logic              cts_n,
	input wire logic              rts_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	AST_START: assert property (tx_valid && tx_ready |=> !txd [*8])
		else $error("start bit short");
	AST_BUSY: assert property (tx_valid && tx_ready |=> !tx_ready [*8])
		else $error("ready in frame");
	AST_IDLE: assert property (tx_ready |-> txd) else $error("idle low");
	// Four samples cover the two-flop sync
	AST_CTS: assert property ((cfg.flow_en && cts_n) [*4] |-> !tx_ready)
		else $error("sent while blocked");
	AST_RTS: assert property (cfg.flow_en ##1 cfg.flow_en |-> rts_n == !$past(rx_room))
		else $error("request line wrong");
	AST_PULSE: assert property (rx_valid |=> !rx_valid) else $error("long pulse");
	AST_HOLD: assert property (!rx_valid |-> $stable(rx_data))
		else $error("word changed");
	AST_PERR: assert property (!rx_valid |-> $stable(rx_par_err))
		else $error("flag changed");
endmodule
bind mhu_uart mhu_uart_chk i_mhu_uart_chk (.clk(clk), .rstn(rstn), .cfg(cfg),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
	.rx_par_err(rx_par_err), .rx_room(rx_room), .txd(txd), .cts_n(cts_n), .rts_n(rts_n));
`default_nettype wire

// file: sim/mhu_host.sv
// Host model: sends characters into the serial input
`timescale 1ns/1ps
`default_nettype none
module mhu_host (
	// Clock and request line
	input  wire logic clk,
	input  wire logic rts_n,
	// Serial output of the host
	output var logic  rxd
);
	logic stalled = 1'b0;
	initial rxd = 1'b1;
	task automatic put(input logic v, input int len);
		rxd = v;
		repeat (len) @(posedge clk);
		#10;
	endtask
	task automatic send(input logic [7:0] d, input int n, p, s, e, input logic fc, input int b);
		int k;
		k = 0;
		while (fc && rts_n && k < 3000) begin
			put(1'b1, 1);
			k++;
		end
		if (k >= 3000)
			stalled = 1'b1;
		put(1'b0, b);
		for (int i = 0; i < n; i++)
			put(d[i], b);
		if (p != 0)
			put(^(d & (8'hFF >> (8 - n))) ^ (p == 1) ^ (e == 1), b);
		// Bad stop only one bit long, else it reads as a new start
		put(e != 2, b);
		put(1'b1, b + b / 2 * s);
	endtask
endmodule
`default_nettype wire

// file: sim/tb_mhu_uart.sv
// Self-checking testbench for the module host serial port
`timescale 1ns/1ps
`default_nettype none
`include "mhu_defines.svh"
module tb_mhu_uart;
	logic              clk = 1'b0;
	logic              rstn = 1'b0;
	mhu_pkg::mhu_cfg_t cfg = '0;
	logic              tx_valid = 1'b0;
	logic [7:0]        tx_data = 8'h00;
	logic              rx_room = 1'b1;
	logic              cts_n = 1'b0;
	logic [15:0]       baud_div = 16'h0001;
	logic              tx_ready, rx_valid, rx_par_err, rx_frm_err, rxd, txd, rts_n;
	logic [7:0]        rx_data;
	int                fail_count = 0;
	int                samples_checked = 0;
	int                rx_seen = 0;
	always #50 clk = ~clk;
	always @(posedge clk)
		if (rx_valid === 1'b1)
			rx_seen++;
	mhu_uart i_mhu_uart (.clk(clk), .rstn(rstn), .baud_div(baud_div), .cfg(cfg),
		.tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_par_err(rx_par_err), .rx_frm_err(rx_frm_err),
		.rx_room(rx_room), .rxd(rxd), .txd(txd), .cts_n(cts_n), .rts_n(rts_n));
	mhu_host i_mhu_host (.clk(clk), .rts_n(rts_n), .rxd(rxd));
	////////////////////////////////////////////////////////////////////////////////
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#10;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wait_ready;
		int k;
		for (k = 0; tx_ready !== 1'b1 && k < 3000; k++)
			tick(1);
		if (tx_ready !== 1'b1) begin
			fail_count++;
			complete_run;
		end
	endtask
	// Sends one word each way at once and checks both
	task automatic xfer(input logic [7:0] d, input int e);
		int         n;
		int         pe;
		int         r;
		logic [7:0] m;
		logic       b;
		int         bd;
		bd = int'(baud_div);
		n = cfg.width + 5;
		pe = (cfg.parity != 2'h0);
		m = 8'hFF >> (8 - n);
		r = rx_seen;
		fork
			i_mhu_host.send(d, n, cfg.parity, cfg.stops, e, cfg.flow_en, 16 * bd);
			begin
				wait_ready;
				tx_valid = 1'b1;
				tx_data = d;
				tick(1);
				tx_valid = 1'b0;
				tick(7 * bd);
				for (int i = 0; i <= n + pe + 1; i++) begin
					b = (i == 0) ? 1'b0 : (i <= n) ? d[i-1] : 1'b1;
					if (pe != 0 && i == n + 1)
						b = ^(d & m) ^ (cfg.parity == 2'h1);
					chk("txd", {7'h00, b}, {7'h00, txd});
					if (i <= n + pe)
						tick(16 * bd);
				end
				tick((8 * cfg.stops + 8) * bd);
				chk("tx_ready", 8'h00, {7'h00, tx_ready});
				wait_ready;
			end
		join
		chk("rx_count", 8'(r + 1), 8'(rx_seen));
		chk("rx_data", d & m, rx_data);
		chk("rx_err", {6'h00, e == 2, e == 1}, {6'h00, rx_frm_err, rx_par_err});
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		tick(10);
		rstn = 1'b1;
		tick(2);
		chk("rts_n", 8'h00, {7'h00, rts_n});
		for (int w = 0; w < 4; w++)
			for (int p = 0; p < 3; p++)
				for (int s = 0; s < 3; s++) begin
					cfg = '{p[1:0], s[1:0], w[1:0], 1'b0};
					xfer(8'hA5 ^ 8'(w * 8 + p * 3 + s), 0);
				end
		baud_div = 16'(`MHU_DIV_DEF);
		xfer(8'h96, 0);
		baud_div = 16'h0001;
		xfer(8'h3C, 1);
		xfer(8'hC3, 2);
		cfg.flow_en = 1'b1;
		cts_n = 1'b1;
		// Let the blocked level pass the pin synchroniser first
		tick(4);
		tx_valid = 1'b1;
		tick(40);
		chk("tx_ready", 8'h00, {7'h00, tx_ready});
		chk("txd", 8'h01, {7'h00, txd});
		tx_valid = 1'b0;
		cts_n = 1'b0;
		rx_room = 1'b0;
		tick(2);
		fork
			xfer(8'h5A, 0);
			begin
				tick(200);
				chk("rts_n", 8'h01, {7'h00, rts_n});
				chk("rx_data", 8'hC3, rx_data);
				rx_room = 1'b1;
			end
		join
		chk("rts_n", 8'h00, {7'h00, rts_n});
		chk("host_wait", 8'h00, {7'h00, i_mhu_host.stalled});
		complete_run;
	end
endmodule
`default_nettype wire
